// [hdl/sfc_pkg.sv]
// Package of constants, modes and state types for the frequency control block
package sfc_pkg;

  localparam int CLK_MHZ = 40;
  localparam int ADDR_W = 6;
  localparam int CTRL_W = 9;
  localparam int MOD_W = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;
  localparam int IDX_W = 13;

  // Byte addresses, one 32-bit word each
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_CMD = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_CARRIER = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_HOP = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_START = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_STOP = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_MARKER = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_SWTIME = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_LOGRATIO = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_RATE_LO = 6'h24;
  localparam logic [ADDR_W-1:0] OFS_RATE_HI = 6'h28;
  localparam logic [ADDR_W-1:0] OFS_FMDEV = 6'h2C;
  localparam logic [ADDR_W-1:0] OFS_MODDIV = 6'h30;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h34;
  localparam logic [ADDR_W-1:0] OFS_PINC = 6'h38;

  // Control and command register fields
  localparam int C_MODE = 0;
  localparam int C_FSK_EXT = 2;
  localparam int C_SRC = 3;
  localparam int C_LOG = 5;
  localparam int C_MARK = 6;
  localparam int C_TOUT = 7;
  localparam int C_MOD_EXT = 8;
  localparam int CMD_TRIG = 0;

  // Reset values
  localparam logic [31:0] SWTIME_RST = 32'h0000_1000;
  localparam logic [31:0] LOGRATIO_RST = 32'h0001_0000;
  localparam logic [15:0] MODDIV_RST = 16'h0028;

  // Arithmetic and timing
  localparam int HOLD_MIN_LOG2 = 8;
  localparam int STEP_LOG2_MAX = 12;
  localparam int FM_SHIFT = 15;
  localparam int LOG_FRAC = 16;
  localparam logic [MOD_W-1:0] INT_SMP_STEP = 16'h0100;
  localparam int TRIG_PULSE_NS = 1000;
  localparam int TRIG_PULSE_CYC = (TRIG_PULSE_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {MODE_CW, MODE_FM, MODE_FSK, MODE_SWEEP} sfc_mode_e;
  typedef enum logic [1:0] {SRC_INT, SRC_EXT, SRC_KEY, SRC_BUS} sfc_src_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } sfc_req_s;

  typedef struct packed {
    logic [1:0] trg_sy;
    logic trg_dly;
    logic [1:0] key_sy;
    logic key_dly;
    logic bus_trig;
    logic [CTRL_W-1:0] ctrl;
    logic [31:0] carrier;
    logic [31:0] hop;
    logic [31:0] f_start;
    logic [31:0] f_stop;
    logic [31:0] marker;
    logic [31:0] sw_time;
    logic [31:0] log_ratio;
    logic [31:0] rate_lo;
    logic [15:0] rate_hi;
    logic [15:0] fm_dev;
    logic [15:0] mod_div;
    logic [15:0] div_cnt;
    logic [MOD_W-1:0] int_smp;
    logic [47:0] key_acc;
    logic sweeping;
    logic sync;
    logic [IDX_W-1:0] step_idx;
    logic [3:0] n_log2;
    logic [31:0] hold_len;
    logic [31:0] hold_cnt;
    logic [31:0] delta;
    logic [31:0] freq;
    logic [5:0] tp_cnt;
    logic trig_out;
    logic [31:0] pinc;
    logic [31:0] phase;
    logic [31:0] rdata;
  } sfc_state_s;

endpackage

// [hdl/sfc_top.sv]
// Frequency control: FM, FSK and stepped sweeps driving the DDS phase increment
`timescale 1ns/1ps

module sfc_fifo #(
  parameter int W = 16,
  parameter int D = 32
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [$clog2(D):0] level_o
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } sfc_fifo_s;

  sfc_fifo_s q, d;
  logic [W-1:0] mem [D];
  logic full, push, pop;

  assign full = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
  assign in_ready_o = !full;
  assign out_valid_o = q.wp != q.rp;
  assign out_data_o = mem[q.rp[AW-1:0]];
  assign level_o = q.wp - q.rp;
  assign push = in_valid_i && !full;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    d = q;
    if (push) begin
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Storage needs no reset; the pointers guard every read
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[q.wp[AW-1:0]] <= in_data_i;
    end
  end
endmodule

module sfc_top
  import sfc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire sfc_req_s bus_req_i,
  output logic [31:0] bus_rdata_o,
  input wire logic mod_valid_i,
  input wire logic [MOD_W-1:0] mod_data_i,
  output logic mod_ready_o,
  input wire logic trig_i,
  output logic trig_o,
  output logic trig_oe_o,
  input wire logic key_i,
  output logic sync_o,
  output logic [31:0] phase_inc_o,
  output logic [31:0] phase_o
);

  function automatic logic [3:0] step_log2(input logic [31:0] t);
    logic [3:0] r;
    r = '0;
    for (int i = 0; i < 32; i++) begin
      if (t[i] && i > HOLD_MIN_LOG2) begin
        r = (i - HOLD_MIN_LOG2 > STEP_LOG2_MAX) ? 4'(STEP_LOG2_MAX) : 4'(i - HOLD_MIN_LOG2);
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] fm_word(input logic [31:0] car, input logic [MOD_W-1:0] smp,
                                          input logic [15:0] dev);
    logic signed [32:0] p;
    logic signed [32:0] s;
    p = $signed(smp) * $signed({1'b0, dev});
    s = p >>> FM_SHIFT;
    return car + s[31:0];
  endfunction

  function automatic logic reached(input logic [31:0] f, input logic [31:0] m,
                                   input logic up);
    return up ? (f >= m) : (f <= m);
  endfunction

  sfc_state_s q, d;
  sfc_mode_e mode;
  sfc_src_e src;
  logic mod_ext, f_in_valid, f_in_ready, f_out_valid, tick, pop;
  logic [MOD_W-1:0] f_in_data, smp;
  logic [LVL_W-1:0] lvl;
  logic ext_edge, key_edge, trig_evt, go, last, key_lvl, up;
  logic [IDX_W-1:0] steps_m1, mid;
  logic [3:0] nl;
  logic [31:0] hl, nf;
  logic [63:0] lprod;

  assign mode = sfc_mode_e'(q.ctrl[C_MODE +: 2]);
  assign src = sfc_src_e'(q.ctrl[C_SRC +: 2]);
  assign mod_ext = q.ctrl[C_MOD_EXT];

  // Sample stream; FIFO drains only at the FM sample rate, so a source stalls
  assign f_in_valid = mod_ext ? mod_valid_i : 1'b1;
  assign f_in_data = mod_ext ? mod_data_i : q.int_smp;
  assign mod_ready_o = mod_ext && f_in_ready;
  assign tick = q.div_cnt == '0;
  assign pop = f_out_valid && tick && mode == MODE_FM;

  sfc_fifo #(.W(MOD_W), .D(FIFO_DEPTH)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .in_valid_i(f_in_valid),
    .in_ready_o(f_in_ready),
    .in_data_i(f_in_data),
    .out_valid_o(f_out_valid),
    .out_ready_i(tick && mode == MODE_FM),
    .out_data_o(smp),
    .level_o(lvl)
  );

  // Edges come from the second sync flop and its delayed copy only
  assign ext_edge = q.trg_sy[1] && !q.trg_dly;
  assign key_edge = q.key_sy[1] && !q.key_dly;
  assign key_lvl = q.ctrl[C_FSK_EXT] ? q.trg_sy[1] : q.key_acc[47];
  assign up = q.f_stop >= q.f_start;
  assign steps_m1 = IDX_W'((14'd1 << q.n_log2) - 14'd1);
  assign mid = IDX_W'((14'd1 << q.n_log2) >> 1);
  assign last = q.sweeping && q.hold_cnt == '0 && q.step_idx == steps_m1;
  assign nl = step_log2(q.sw_time);
  assign hl = ((q.sw_time >> nl) == '0) ? 32'h0000_0001 : (q.sw_time >> nl);
  assign lprod = q.freq * q.log_ratio;
  assign nf = q.ctrl[C_LOG] ? lprod[LOG_FRAC +: 32] : q.freq + q.delta;

  always_comb begin
    case (src)
      SRC_INT: trig_evt = 1'b1;
      SRC_EXT: trig_evt = ext_edge;
      SRC_KEY: trig_evt = key_edge;
      default: trig_evt = q.bus_trig;
    endcase
  end

  // A trigger during a running sweep is dropped; only the last step may chain
  assign go = mode == MODE_SWEEP && (!q.sweeping || last) && trig_evt;

  always_comb begin
    d = q;
    d.trg_sy = {q.trg_sy[0], trig_i};
    d.trg_dly = q.trg_sy[1];
    d.key_sy = {q.key_sy[0], key_i};
    d.key_dly = q.key_sy[1];
    d.bus_trig = 1'b0;
    d.rdata = '0;
    if (bus_req_i.wr) begin
      if (bus_req_i.addr == OFS_CTRL) begin
        d.ctrl = bus_req_i.wdata[CTRL_W-1:0];
      end else if (bus_req_i.addr == OFS_CMD) begin
        d.bus_trig = bus_req_i.wdata[CMD_TRIG];
      end else if (bus_req_i.addr == OFS_CARRIER) begin
        d.carrier = bus_req_i.wdata;
      end else if (bus_req_i.addr == OFS_HOP) begin
        d.hop = bus_req_i.wdata;
      end else if (bus_req_i.addr == OFS_START) begin
        d.f_start = bus_req_i.wdata;
      end else if (bus_req_i.addr == OFS_STOP) begin
        d.f_stop = bus_req_i.wdata;
      end else if (bus_req_i.addr == OFS_MARKER) begin
        d.marker = bus_req_i.wdata;
      end else if (bus_req_i.addr == OFS_SWTIME) begin
        d.sw_time = bus_req_i.wdata;
      end else if (bus_req_i.addr == OFS_LOGRATIO) begin
        d.log_ratio = bus_req_i.wdata;
      end else if (bus_req_i.addr == OFS_RATE_LO) begin
        d.rate_lo = bus_req_i.wdata;
      end else if (bus_req_i.addr == OFS_RATE_HI) begin
        d.rate_hi = bus_req_i.wdata[15:0];
      end else if (bus_req_i.addr == OFS_FMDEV) begin
        d.fm_dev = bus_req_i.wdata[15:0];
      end else if (bus_req_i.addr == OFS_MODDIV) begin
        d.mod_div = bus_req_i.wdata[15:0];
      end
    end
    if (bus_req_i.rd) begin
      if (bus_req_i.addr == OFS_CTRL) begin
        d.rdata = 32'(q.ctrl);
      end else if (bus_req_i.addr == OFS_CARRIER) begin
        d.rdata = q.carrier;
      end else if (bus_req_i.addr == OFS_HOP) begin
        d.rdata = q.hop;
      end else if (bus_req_i.addr == OFS_START) begin
        d.rdata = q.f_start;
      end else if (bus_req_i.addr == OFS_STOP) begin
        d.rdata = q.f_stop;
      end else if (bus_req_i.addr == OFS_MARKER) begin
        d.rdata = q.marker;
      end else if (bus_req_i.addr == OFS_SWTIME) begin
        d.rdata = q.sw_time;
      end else if (bus_req_i.addr == OFS_LOGRATIO) begin
        d.rdata = q.log_ratio;
      end else if (bus_req_i.addr == OFS_RATE_LO) begin
        d.rdata = q.rate_lo;
      end else if (bus_req_i.addr == OFS_RATE_HI) begin
        d.rdata = 32'(q.rate_hi);
      end else if (bus_req_i.addr == OFS_FMDEV) begin
        d.rdata = 32'(q.fm_dev);
      end else if (bus_req_i.addr == OFS_MODDIV) begin
        d.rdata = 32'(q.mod_div);
      end else if (bus_req_i.addr == OFS_STATUS) begin
        d.rdata = 32'({q.step_idx, q.n_log2, lvl, key_lvl, q.sync, q.sweeping});
      end else if (bus_req_i.addr == OFS_PINC) begin
        d.rdata = q.pinc;
      end
    end

    // Sample pacing and the internal ramp source
    d.div_cnt = tick ? q.mod_div : q.div_cnt - 16'h0001;
    if (!mod_ext && f_in_ready) begin
      d.int_smp = q.int_smp + INT_SMP_STEP;
    end

    // 48 bits reach about 0.14 uHz resolution at 40 MHz; MSB is a 50% square
    d.key_acc = q.key_acc + {q.rate_hi, q.rate_lo};

    // Sweep sequencer
    if (go) begin
      d.sweeping = 1'b1;
      d.step_idx = '0;
      d.freq = q.f_start;
      d.n_log2 = nl;
      d.hold_len = hl;
      d.hold_cnt = hl - 32'h0000_0001;
      d.delta = 32'($signed(q.f_stop - q.f_start) >>> nl);
      d.sync = 1'b1;
      if (src == SRC_INT) begin
        d.tp_cnt = 6'(TRIG_PULSE_CYC);
      end
    end else if (q.sweeping) begin
      if (q.hold_cnt != '0) begin
        d.hold_cnt = q.hold_cnt - 32'h0000_0001;
      end else if (last) begin
        d.sweeping = 1'b0;
        d.sync = 1'b0;
      end else begin
        d.step_idx = q.step_idx + 1'b1;
        d.freq = nf;
        d.hold_cnt = q.hold_len - 32'h0000_0001;
        if (!q.ctrl[C_MARK] && d.step_idx == mid) begin
          d.sync = 1'b0;
        end
        if (q.ctrl[C_MARK] && reached(nf, q.marker, up)) begin
          d.sync = 1'b0;
        end
      end
    end
    if (mode != MODE_SWEEP) begin
      d.sweeping = 1'b0;
      d.sync = 1'b0;
    end
    if (q.tp_cnt != '0 && !go) begin
      d.tp_cnt = q.tp_cnt - 6'd1;
    end
    d.trig_out = d.tp_cnt != '0;

    // Phase increment source; accumulator keeps running across every change
    case (mode)
      MODE_CW: d.pinc = q.carrier;
      MODE_FM: d.pinc = pop ? fm_word(q.carrier, smp, q.fm_dev) : q.pinc;
      MODE_FSK: d.pinc = key_lvl ? q.hop : q.carrier;
      default: d.pinc = q.freq;
    endcase
    d.phase = q.phase + q.pinc;
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
      q.sw_time <= SWTIME_RST;
      q.log_ratio <= LOGRATIO_RST;
      q.mod_div <= MODDIV_RST;
    end else begin
      q <= d;
    end
  end

  assign bus_rdata_o = q.rdata;
  assign trig_o = q.trig_out;
  // Pin is an output only while it is not the selected trigger input
  assign trig_oe_o = q.ctrl[C_TOUT] && src != SRC_EXT;
  assign sync_o = q.sync;
  assign phase_inc_o = q.pinc;
  assign phase_o = q.phase;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_ext_edge;
    mode == MODE_SWEEP && src == SRC_EXT && !q.sweeping && ext_edge;
  endsequence
  sequence s_started;
    q.sweeping && q.sync && q.step_idx == '0 && q.freq == $past(q.f_start);
  endsequence

  chk_fm_load: assert property (pop |=>
    q.pinc == fm_word($past(q.carrier), $past(smp), $past(q.fm_dev)))
    else $error("FM sample not applied to phase increment");
  chk_fsk_pin: assert property (mode == MODE_FSK && q.ctrl[C_FSK_EXT] |=>
    q.pinc == ($past(q.trg_sy[1]) ? $past(q.hop) : $past(q.carrier)))
    else $error("External keying picked wrong word");
  chk_fsk_square: assert property (mode == MODE_FSK && !q.ctrl[C_FSK_EXT] |=>
    q.pinc == ($past(q.key_acc[47]) ? $past(q.hop) : $past(q.carrier)))
    else $error("Internal keying picked wrong word");
  chk_phase_cont: assert property ($changed(q.pinc) |=>
    q.phase == $past(q.phase) + $past(q.pinc))
    else $error("Phase accumulator disturbed at frequency change");
  chk_int_repeat: assert property (
    mode == MODE_SWEEP && src == SRC_INT && !q.sweeping |=> s_started)
    else $error("Internal sweep did not restart");
  chk_ext_start: assert property (s_ext_edge |=> s_started)
    else $error("Trigger pulse did not start a sweep");
  chk_step_adv: assert property (
    q.sweeping && mode == MODE_SWEEP && q.hold_cnt == '0 && !last |=>
    q.step_idx == $past(q.step_idx) + 1'b1 && q.hold_cnt == $past(q.hold_len) - 1)
    else $error("Sweep step did not advance after hold");
  chk_trig_pulse: assert property (go && src == SRC_INT |=> trig_o [*8])
    else $error("Trigger output pulse too short");
  chk_mid_low: assert property (
    $fell(q.sync) && q.sweeping && !q.ctrl[C_MARK] |-> q.step_idx == mid)
    else $error("Sync fell away from sweep midpoint");
  chk_marker_low: assert property (
    $fell(q.sync) && q.sweeping && q.ctrl[C_MARK] |-> reached(q.freq, q.marker, up))
    else $error("Sync fell before marker frequency");

endmodule

// [verif/sfc_partner.sv]
// Far-side model: trigger pin source and external modulation sample source
`timescale 1ns/1ps
module sfc_partner
  import sfc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic trig_lvl_i,
  input wire logic trig_oe_i,
  input wire logic trig_drv_i,
  output logic trig_pin_o,
  input wire logic push_i,
  input wire logic [MOD_W-1:0] smp_i,
  input wire logic [1:0] gap_i,
  output logic full_o,
  output logic mod_valid_o,
  output logic [MOD_W-1:0] mod_data_o,
  input wire logic mod_ready_i
);
  logic [MOD_W-1:0] val_q;
  logic [1:0] gap_q;

  // The device owns the pin whenever its output enable is up
  assign trig_pin_o = trig_oe_i ? trig_drv_i : trig_lvl_i;

  // Valid and data hold until the ready edge; idle data toggles so a stale word never passes
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      full_o <= 1'b0;
      mod_valid_o <= 1'b0;
      mod_data_o <= '0;
      val_q <= '0;
      gap_q <= 2'h0;
    end else begin
      if (mod_valid_o && mod_ready_i) begin
        mod_valid_o <= 1'b0;
        full_o <= 1'b0;
        mod_data_o <= ~mod_data_o;
      end else if (!mod_valid_o) begin
        if (full_o && gap_q == 2'h0) begin
          mod_valid_o <= 1'b1;
          mod_data_o <= val_q;
        end else begin
          mod_data_o <= ~mod_data_o;
          gap_q <= (gap_q == 2'h0) ? 2'h0 : gap_q - 2'h1;
        end
      end
      if (push_i) begin
        full_o <= 1'b1;
        val_q <= smp_i;
        gap_q <= gap_i;
      end
    end
  end
endmodule

// [verif/tb_sweep_fsk_frequency_control.sv]
// Self-checking bench for the FM, FSK and sweep frequency control block
`timescale 1ns/1ps
module tb_sweep_fsk_frequency_control
  import sfc_pkg::*;
();
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  sfc_req_s req = '0;
  logic [31:0] bus_rdata_o, phase_inc_o, phase_o;
  logic mod_ready_o, trig_o, trig_oe_o, sync_o, trig_pin, mod_valid, full;
  logic key_i = 1'b0;
  logic trig_lvl = 1'b0;
  logic push = 1'b0;
  logic [1:0] gap = 2'h0;
  logic [MOD_W-1:0] mod_data;
  logic [MOD_W-1:0] smp = 16'h0000;
  logic [31:0] seed = 32'h0001_335D;
  logic [15:0] q[$];
  int n_errors = 0;
  int n_tests = 0;
  logic [ADDR_W-1:0] ra [6] = '{OFS_CTRL, OFS_CMD, OFS_SWTIME, OFS_LOGRATIO, OFS_MODDIV, 6'h3C};
  logic [31:0] rv [6] = '{32'h0, 32'h0, SWTIME_RST, LOGRATIO_RST, {16'h0, MODDIV_RST}, 32'h0};

  sfc_top u_sfc_top (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus_req_i(req),
    .bus_rdata_o(bus_rdata_o), .mod_valid_i(mod_valid), .mod_data_i(mod_data),
    .mod_ready_o(mod_ready_o), .trig_i(trig_pin), .trig_o(trig_o), .trig_oe_o(trig_oe_o),
    .key_i(key_i), .sync_o(sync_o), .phase_inc_o(phase_inc_o), .phase_o(phase_o));

  sfc_partner u_sfc_partner (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .trig_lvl_i(trig_lvl),
    .trig_oe_i(trig_oe_o), .trig_drv_i(trig_o), .trig_pin_o(trig_pin), .push_i(push),
    .smp_i(smp), .gap_i(gap), .full_o(full), .mod_valid_o(mod_valid), .mod_data_o(mod_data),
    .mod_ready_i(mod_ready_o));

  always #12.5 ref_clk_i = ~ref_clk_i;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Steps per sweep are 2^n, with n growing with the sweep time
  function automatic int steps_log2(input logic [31:0] sw);
    int m;
    m = 0;
    for (int i = 0; i < 32; i++) begin
      if (sw[i]) m = i;
    end
    m = (m < HOLD_MIN_LOG2) ? 0 : m - HOLD_MIN_LOG2;
    return (m > STEP_LOG2_MAX) ? STEP_LOG2_MAX : m;
  endfunction

  function automatic int hold_of(input logic [31:0] sw);
    return int'(sw >> steps_log2(sw));
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic timeout();
    chk(32'h0, 32'h1);
    wrap_up();
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge ref_clk_i);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge ref_clk_i);
    req.rd <= 1'b0;
    @(negedge ref_clk_i);
    d = bus_rdata_o;
  endtask

  // Returns the number of cycles until sync reaches the level
  task automatic wait_sync(input logic v, output int c);
    c = 0;
    while (sync_o !== v) begin
      @(negedge ref_clk_i);
      c++;
      if (c > 20000) timeout();
    end
  endtask

  task automatic nxt(output logic [31:0] v);
    int k;
    v = phase_inc_o;
    k = 0;
    while (phase_inc_o === v) begin
      @(negedge ref_clk_i);
      k++;
      if (k > 2000) timeout();
    end
    v = phase_inc_o;
  endtask

  task automatic cont_chk(input int n);
    logic [31:0] p, i;
    @(negedge ref_clk_i);
    repeat (n) begin
      p = phase_o;
      i = phase_inc_o;
      @(negedge ref_clk_i);
      chk(phase_o - p, i);
    end
  endtask

  task automatic pulse(input logic use_key);
    @(posedge ref_clk_i);
    key_i <= use_key;
    trig_lvl <= !use_key;
    repeat (4) @(posedge ref_clk_i);
    key_i <= 1'b0;
    trig_lvl <= 1'b0;
  endtask

  // Odd samples tell the external stream apart from the internal even ramp
  task automatic feed(input int n);
    logic [31:0] r;
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      @(negedge ref_clk_i);
      while (full === 1'b1) begin
        @(negedge ref_clk_i);
        k++;
        if (k > 5000) timeout();
      end
      r = rnd() | 32'h1;
      q.push_back(r[15:0]);
      @(posedge ref_clk_i);
      smp <= r[15:0];
      gap <= r[17:16];
      push <= 1'b1;
      @(posedge ref_clk_i);
      push <= 1'b0;
    end
  endtask

  initial begin
    logic [31:0] d, c, v;
    logic [15:0] s;
    int a, b, n;
    repeat (6) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], d);
      chk(d, rv[i]);
    end
    c = rnd();
    wr(OFS_CARRIER, c);
    rd(OFS_CARRIER, d);
    chk(d, c);
    chk(phase_inc_o, c);
    $display("test registers done");
    wr(OFS_HOP, ~c);
    wr(OFS_CTRL, 32'h0000_0006);
    repeat (8) @(negedge ref_clk_i);
    chk(phase_inc_o, c);
    @(posedge ref_clk_i);
    trig_lvl <= 1'b1;
    cont_chk(8);
    chk(phase_inc_o, ~c);
    @(posedge ref_clk_i);
    trig_lvl <= 1'b0;
    wr(OFS_HOP, c ^ 32'h8000_0000);
    wr(OFS_RATE_LO, 32'h0);
    wr(OFS_RATE_HI, 32'h0000_0400);
    wr(OFS_CTRL, 32'h0000_0002);
    repeat (70) @(negedge ref_clk_i);
    a = 0;
    repeat (640) begin
      @(negedge ref_clk_i);
      a += int'(phase_inc_o === (c ^ 32'h8000_0000));
    end
    chk(32'(a), 32'(640 / 2));
    $display("test keying done");
    n = steps_log2(32'h400);
    wr(OFS_SWTIME, 32'h0000_0400);
    wr(OFS_START, 32'h0000_2000);
    wr(OFS_STOP, 32'h0000_2400);
    wr(OFS_CTRL, 32'h0000_008B);
    @(negedge ref_clk_i);
    chk(32'(trig_oe_o), 32'h0);
    pulse(1'b0);
    wait_sync(1'b1, a);
    wait_sync(1'b0, a);
    chk(32'(a), 32'(((1 << n) / 2) * hold_of(32'h400)));
    repeat (4) @(negedge ref_clk_i);
    chk(phase_inc_o, 32'h2000 + 2 * (32'h400 >> n));
    a = 0;
    repeat (2000) begin
      @(negedge ref_clk_i);
      a += int'(sync_o === 1'b1);
    end
    chk(32'(a), 32'h0);
    rd(OFS_STATUS, d);
    chk({31'h0, d[0]}, 32'h0);
    wr(OFS_LOGRATIO, 32'h0002_0000);
    wr(OFS_START, 32'h0000_1000);
    wr(OFS_STOP, 32'h0000_8000);
    wr(OFS_MARKER, 32'h0000_8000);
    wr(OFS_CTRL, 32'h0000_006B);
    pulse(1'b0);
    wait_sync(1'b1, a);
    wait_sync(1'b0, a);
    chk(32'(a), 32'(3 * hold_of(32'h400)));
    repeat (4) @(negedge ref_clk_i);
    chk(phase_inc_o, 32'h0000_8000);
    $display("test external sweep done");
    wr(OFS_CTRL, 32'h0000_0083);
    wait_sync(1'b1, a);
    wait_sync(1'b0, a);
    wait_sync(1'b1, b);
    chk(32'(a + b), 32'((1 << n) * hold_of(32'h400)));
    chk(32'(trig_oe_o), 32'h1);
    a = 0;
    repeat (1024) begin
      @(negedge ref_clk_i);
      a += int'(trig_o === 1'b1);
    end
    chk(32'(a), 32'(TRIG_PULSE_CYC));
    rd(OFS_STATUS, d);
    chk(32'(d[12:9]), 32'(n));
    for (int k = 0; k < 2; k++) begin
      wr(OFS_CTRL, 32'h0);
      wr(OFS_CTRL, (k == 0) ? 32'h0000_0013 : 32'h0000_001B);
      if (k == 0) begin
        pulse(1'b1);
      end else begin
        wr(OFS_CMD, 32'h1);
      end
      wait_sync(1'b1, a);
      chk(32'(sync_o), 32'h1);
      // The start must follow the trigger within a few cycles, not by some other path
      chk(32'(a <= 4), 32'h1);
    end
    $display("test trigger sources done");
    c = rnd() & 32'hFFFF_0000;
    wr(OFS_CARRIER, c);
    wr(OFS_FMDEV, 32'h0000_8000);
    wr(OFS_CTRL, 32'h0000_0001);
    nxt(v);
    nxt(v);
    nxt(d);
    chk(d - v, 32'(INT_SMP_STEP));
    wr(OFS_MODDIV, 32'h3);
    wr(OFS_CTRL, 32'h0000_0100);
    fork
      feed(40);
      begin
        repeat (300) @(negedge ref_clk_i);
        chk(32'(mod_ready_o), 32'h0);
        rd(OFS_STATUS, d);
        chk(32'(d[8:3]), 32'(FIFO_DEPTH));
        wr(OFS_CTRL, 32'h0000_0101);
        a = 0;
        b = 0;
        while (a < 40 && b < 400) begin
          nxt(v);
          b++;
          if (v[0] === 1'b1) begin
            s = q.pop_front();
            chk(v, c + {{16{s[15]}}, s});
            a++;
          end
        end
        chk(32'(a), 32'd40);
      end
    join
    repeat (200) @(negedge ref_clk_i);
    rd(OFS_STATUS, d);
    chk(32'(d[8:3]), 32'h0);
    $display("test modulation stream done");
    wrap_up();
  end
endmodule
